// *** verilog/hr_frame_packer_regs.vh ***
// Constants for the half-rate speech frame packer.
// Assumes inclusion by bare name from the packer's design files.
`ifndef HR_FRAME_PACKER_REGS_VH
`define HR_FRAME_PACKER_REGS_VH

// ----------------------------------------------------------------------------
// Frame type selects
// ----------------------------------------------------------------------------
`define SEL_VOICED        2'h0
`define SEL_UNVOICED      2'h1
`define SEL_INTEROP_1265  2'h2

// ----------------------------------------------------------------------------
// Header codes
// ----------------------------------------------------------------------------
`define VOICED_TYPE_CODE   3'h7
`define UNVOICED_TYPE_CODE 2'h2
`define INTEROP_OCTET1     8'hDF
`define INTEROP_FRAME_TYPE 4'h2
`define INTEROP_QUALITY    1'h1

// ----------------------------------------------------------------------------
// Packet geometry
// ----------------------------------------------------------------------------
`define PACKET_BITS        128
`define PACKET_OCTETS      5'h10
`define LAST_OCTET         4'hF
`define INTEROP_BITS       111
`define TABLE_INDEX_W      7
`define TRAILING_PAD       4'h0

`endif

// *** verilog/two_entry_buffer.v ***
// Two-entry buffer between the octet serializer and the multiplex sublayer.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps

module two_entry_buffer
#(
	parameter WIDTH = 9
)
(
	input  wire             core_clk,
	input  wire             arst_n,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);

reg [WIDTH-1:0] head_r;
reg             headValid_r;
reg [WIDTH-1:0] spare_r;
reg             spareValid_r;

// ----------------------------------------------------------------------------
// Storage
// ----------------------------------------------------------------------------
// The spare entry catches a word that arrives while the head is stalled.
assign inReady  = !spareValid_r;
assign outData  = head_r;
assign outValid = headValid_r;

always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		head_r       <= {WIDTH{1'b0}};
		headValid_r  <= 1'b0;
		spare_r      <= {WIDTH{1'b0}};
		spareValid_r <= 1'b0;
	end
	else if (outReady || !headValid_r)
	begin
		if (spareValid_r)
		begin
			head_r       <= spare_r;
			headValid_r  <= 1'b1;
			spareValid_r <= 1'b0;
		end
		else
		begin
			head_r      <= inData;
			headValid_r <= inValid;
		end
	end
	else if (inValid && !spareValid_r)
	begin
		spare_r      <= inData;
		spareValid_r <= 1'b1;
	end
end

endmodule

// *** verilog/half_rate_frame_packer.v ***
// Half-rate speech frame packer: builds a 16-octet packet from one frame of
// encoder parameters and sends it octet by octet through a two-entry buffer.
// Assumes the parameter source holds its inputs until frameDone.
`timescale 1ns/10ps
`include "hr_frame_packer_regs.vh"

// Summary of operation
// [R1] Voiced: type 111, 36 spectral, 9 lag
// [R2] Voiced subframes 1,3: filter, index, flag, gain
// [R3] Voiced subframes 2,4: index then gain only
// [R4] Unvoiced: type 10, 46 spectral bits
// [R5] Unvoiced subframes: 13 index, 6 gain bits
// [R6] Unvoiced subframes packed from octet 7
// [R7] Bits packed most significant first
// [R8] Interoperable frame drops trailing index bits
// [R9] Interoperable bits reordered by priority table
// [R10] Interoperable 12.65 is its own frame type
// [R11] 111 ordered bits, each chosen by table
// [R12] Octet1 11011111, type 0010, quality one
// [R13] Unused final bits zero, 16 octets always
// [R14] Source holds frame until packer completes
module half_rate_frame_packer
(
	input  wire         core_clk,
	input  wire         arst_n,
	input  wire         frameValid,
	output wire         frameReady,
	input  wire [1:0]   frameType,
	input  wire [0:45]  spectralParamBits,
	input  wire [0:8]   pitchLag,
	input  wire [0:1]   pitchFilterBit,
	input  wire [0:1]   gainSelectFlag,
	input  wire [0:51]  fixedCodebookIndex,
	input  wire [0:23]  codebookGain,
	input  wire [0:110] interopSourceBits,
	input  wire         tableWrEn,
	input  wire [6:0]   tableWrIndex,
	input  wire [6:0]   tableWrValue,
	output reg          frameDone,
	output wire [7:0]   octetData,
	output wire         octetLast,
	output wire         octetValid,
	input  wire         octetReady
);

localparam ST_IDLE = 1'b0;
localparam ST_SEND = 1'b1;

reg                     state_r;
reg                     state_nxt;
reg [0:127]             packet_r;
reg [0:127]             packet_nxt;
reg [3:0]               octetIdx_r;
reg [3:0]               octetIdx_nxt;
reg [6:0]               priorityTable_r [0:110];
reg [0:110]             tableLoaded_r;
reg [6:0]               srcIndex;
reg [0:110]             orderedBits;
reg                     frameDone_nxt;
wire                    bufInReady;
wire [8:0]              bufInWord;
wire                    bufInValid;
wire [8:0]              bufOutWord;
wire                    legalType;
wire                    accept;
wire                    push;
integer                 k;

// ----------------------------------------------------------------------------
// Field builders
// ----------------------------------------------------------------------------
// Subframe 1 or 3 of a voiced frame: filter, 12 index bits, flag, gain.
function [0:19] voicedOddSub;
	input       filt;
	input [0:11] idx;
	input       flag;
	input [0:5] gain;
	begin
		voicedOddSub = {filt, idx, flag, gain}; // R2
	end
endfunction

// Subframe 2 or 4 of a voiced frame: 12 index bits then gain.
function [0:17] voicedEvenSub;
	input [0:11] idx;
	input [0:5]  gain;
	begin
		voicedEvenSub = {idx, gain}; // R3
	end
endfunction

// Subframe of an unvoiced frame: 13 index bits then gain.
function [0:18] unvoicedSub;
	input [0:12] idx;
	input [0:5]  gain;
	begin
		unvoicedSub = {idx, gain}; // R5
	end
endfunction

// Table entries and source indices past the last speech bit are ignored.
function inTableRange;
	input [6:0] idx;
	begin
		inTableRange = (idx < `INTEROP_BITS); // R11
	end
endfunction

// The sixteenth octet carries the last flag and ends the frame.
function isLastOctet;
	input [3:0] idx;
	begin
		isLastOctet = (idx == `LAST_OCTET); // R13
	end
endfunction

// Only the three packed layouts are accepted; code 3 is refused.
function legalFrameType;
	input [1:0] sel;
	begin
		legalFrameType = (sel == `SEL_VOICED) || (sel == `SEL_UNVOICED) || (sel == `SEL_INTEROP_1265); // R10
	end
endfunction

// ----------------------------------------------------------------------------
// Priority table
// ----------------------------------------------------------------------------
// An entry that was never written reads as the identity order, so reset
// clears one flag per entry instead of loading the whole array.
always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		tableLoaded_r <= {`INTEROP_BITS{1'b0}};
	end
	else if (tableWrEn && inTableRange(tableWrIndex))
	begin
		tableLoaded_r[tableWrIndex] <= 1'b1;
	end
end

always @(posedge core_clk)
begin
	if (tableWrEn && inTableRange(tableWrIndex))
	begin
		priorityTable_r[tableWrIndex] <= tableWrValue;
	end
end

// ----------------------------------------------------------------------------
// Priority reordering
// ----------------------------------------------------------------------------
// Output bit j takes the source bit that table entry j names.
always @*
begin
	orderedBits = {`INTEROP_BITS{1'b0}};
	srcIndex    = 7'h00;
	for (k = 0; k < `INTEROP_BITS; k = k + 1)
	begin
		srcIndex = tableLoaded_r[k] ? priorityTable_r[k] : k[6:0];
		if (inTableRange(srcIndex))
		begin
			orderedBits[k] = interopSourceBits[srcIndex]; // R9 R11
		end
	end
end

// ----------------------------------------------------------------------------
// Packet assembly
// ----------------------------------------------------------------------------
// Index 0 of the packet is bit 8 of octet 1; later bits fill downward.
always @*
begin
	packet_nxt = {`PACKET_BITS{1'b0}};
	case (frameType)
	`SEL_VOICED:
	begin
		packet_nxt = {`VOICED_TYPE_CODE, spectralParamBits[0:35], pitchLag, // R1
			voicedOddSub(pitchFilterBit[0], fixedCodebookIndex[0:11],
				gainSelectFlag[0], codebookGain[0:5]),
			voicedEvenSub(fixedCodebookIndex[13:24], codebookGain[6:11]),
			voicedOddSub(pitchFilterBit[1], fixedCodebookIndex[26:37],
				gainSelectFlag[1], codebookGain[12:17]),
			voicedEvenSub(fixedCodebookIndex[39:50], codebookGain[18:23]),
			`TRAILING_PAD}; // R7 R13
	end
	`SEL_UNVOICED:
	begin
		packet_nxt = {`UNVOICED_TYPE_CODE, spectralParamBits, // R4
			unvoicedSub(fixedCodebookIndex[0:12], codebookGain[0:5]), // R6
			unvoicedSub(fixedCodebookIndex[13:25], codebookGain[6:11]),
			unvoicedSub(fixedCodebookIndex[26:38], codebookGain[12:17]),
			unvoicedSub(fixedCodebookIndex[39:51], codebookGain[18:23]),
			`TRAILING_PAD}; // R7 R13
	end
	`SEL_INTEROP_1265:
	begin
		// The source already omits index bits beyond the half-rate size.
		packet_nxt = {`INTEROP_OCTET1, `INTEROP_FRAME_TYPE, `INTEROP_QUALITY, // R12
			orderedBits, `TRAILING_PAD}; // R8 R10 R13
	end
	default:
	begin
		packet_nxt = {`PACKET_BITS{1'b0}};
	end
	endcase
end

// ----------------------------------------------------------------------------
// Frame handshake and serializer
// ----------------------------------------------------------------------------
// Unknown frame types are refused by holding frameReady low.
assign legalType  = legalFrameType(frameType); // R10
assign frameReady = (state_r == ST_IDLE) && legalType;
assign accept     = frameValid && frameReady; // R14
assign push       = bufInValid && bufInReady;

// frameDone rises on the edge that returns to idle, so the next frame can be taken on the following edge.
always @*
begin
	state_nxt     = state_r;
	octetIdx_nxt  = octetIdx_r;
	frameDone_nxt = 1'b0;
	case (state_r)
	ST_IDLE:
	begin
		if (accept)
		begin
			state_nxt    = ST_SEND;
			octetIdx_nxt = 4'h0;
		end
	end
	ST_SEND:
	begin
		if (push)
		begin
			octetIdx_nxt = octetIdx_r + 4'h1;
			if (isLastOctet(octetIdx_r))
			begin
				state_nxt     = ST_IDLE; // R13
				frameDone_nxt = 1'b1; // R14
			end
		end
	end
	default:
	begin
		state_nxt = ST_IDLE;
	end
	endcase
end

always @(posedge core_clk or negedge arst_n)
begin
	if (!arst_n)
	begin
		state_r    <= ST_IDLE;
		octetIdx_r <= 4'h0;
		packet_r   <= {`PACKET_BITS{1'b0}};
		frameDone  <= 1'b0;
	end
	else
	begin
		state_r    <= state_nxt;
		octetIdx_r <= octetIdx_nxt;
		frameDone  <= frameDone_nxt;
		// The packet is latched on the take edge, then shifted one octet per push.
		if (accept)
		begin
			packet_r <= packet_nxt;
		end
		else if (push)
		begin
			packet_r <= {packet_r[8:127], 8'h00}; // R7
		end
	end
end

// ----------------------------------------------------------------------------
// Output buffer
// ----------------------------------------------------------------------------
// Bit 8 of the buffer word marks the sixteenth octet for the sink.
assign bufInWord  = {isLastOctet(octetIdx_r), packet_r[0:7]}; // R13
assign bufInValid = (state_r == ST_SEND);

two_entry_buffer
#(
	.WIDTH (9)
)
u_buffer
(
	.core_clk (core_clk),
	.arst_n   (arst_n),
	.inData   (bufInWord),
	.inValid  (bufInValid),
	.inReady  (bufInReady),
	.outData  (bufOutWord),
	.outValid (octetValid),
	.outReady (octetReady)
);

assign octetData = bufOutWord[7:0];
assign octetLast = bufOutWord[8];

endmodule

// *** test/half_rate_frame_packer_asserts.sv ***
// Port checker for the half-rate frame packer.
// Assumes it is bound onto every half_rate_frame_packer instance.
`timescale 1ns/10ps
module half_rate_frame_packer_asserts
(
	input wire logic       core_clk,
	input wire logic       arst_n,
	input wire logic       frameValid,
	input wire logic       frameReady,
	input wire logic [1:0] frameType,
	input wire logic       frameDone,
	input wire logic [7:0] octetData,
	input wire logic       octetLast,
	input wire logic       octetValid,
	input wire logic       octetReady
);
	reg [3:0] cnt_r;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	// Counts octets taken so the position within a packet is known.
	always @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			cnt_r <= 4'h0;
		else if (octetValid && octetReady)
			cnt_r <= cnt_r + 4'h1;
	property p_refuse; frameType == 2'h3 |-> !frameReady; endproperty
	a_refuse: assert property (p_refuse) else $error("illegal type accepted");
	property p_busy; frameValid && frameReady |=> !frameReady; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	property p_early; frameValid && frameReady |=> (!frameDone)[*8]; endproperty
	a_early: assert property (p_early) else $error("done too early");
	property p_pulse; frameDone |=> !frameDone; endproperty
	a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
	property p_idle; frameDone |-> frameReady || frameType == 2'h3; endproperty
	a_idle: assert property (p_idle) else $error("not idle at done");
	property p_hold; octetValid && !octetReady |=> octetValid && $stable(octetData) && $stable(octetLast); endproperty
	a_hold: assert property (p_hold) else $error("octet changed while stalled");
	property p_pad; octetValid && octetLast |-> octetData[3:0] == 4'h0; endproperty
	a_pad: assert property (p_pad) else $error("pad bits not zero");
	property p_last; octetValid |-> octetLast == (cnt_r == 4'hF); endproperty
	a_last: assert property (p_last) else $error("last flag misplaced");
	property p_first; octetValid && cnt_r == 4'h0 |-> octetData[7]; endproperty
	a_first: assert property (p_first) else $error("type code bit 8 low");
endmodule
bind half_rate_frame_packer half_rate_frame_packer_asserts i_chk(.core_clk(core_clk), .arst_n(arst_n),
	.frameValid(frameValid), .frameReady(frameReady), .frameType(frameType), .frameDone(frameDone),
	.octetData(octetData), .octetLast(octetLast), .octetValid(octetValid), .octetReady(octetReady));

// *** test/octet_sink_model.sv ***
// Multiplex sublayer model that takes octets with random stalls.
// Assumes the bench has seeded the random generator.
`timescale 1ns/10ps
module octet_sink_model
(
	input  wire core_clk,
	input  wire arst_n,
	input  wire slow,
	output reg  octetReady
);
	initial octetReady = 1'b0;
	// Slow mode stalls three cycles in four so the buffer fills up.
	always @(posedge core_clk)
		octetReady <= #1 arst_n && (slow ? $urandom_range(3) == 0 : $urandom_range(3) != 0);
endmodule

// *** test/half_rate_frame_packer_tb.sv ***
// Self-checking bench for the half-rate frame packer.
// Assumes the checker and the sink model are compiled beforehand.
`timescale 1ns/10ps
module half_rate_frame_packer_tb;
	reg           core_clk, arst_n, frameValid, tableWrEn, slow;
	reg   [1:0]   frameType;
	reg   [0:45]  spectralParamBits;
	reg   [0:8]   pitchLag;
	reg   [0:1]   pitchFilterBit, gainSelectFlag;
	reg   [0:51]  fixedCodebookIndex;
	reg   [0:23]  codebookGain;
	reg   [0:110] interopSourceBits;
	reg   [6:0]   tableWrIndex, tableWrValue;
	reg   [6:0]   tbl [0:110];
	reg   [127:0] got;
	reg   [127:0] expQ [$];
	wire          frameReady, frameDone, octetLast, octetValid, octetReady;
	wire  [7:0]   octetData;
	integer       bad_count, cmp_count, n, pkts, i;
	half_rate_frame_packer i_half_rate_frame_packer(.core_clk(core_clk), .arst_n(arst_n),
		.frameValid(frameValid), .frameReady(frameReady), .frameType(frameType),
		.spectralParamBits(spectralParamBits), .pitchLag(pitchLag), .pitchFilterBit(pitchFilterBit),
		.gainSelectFlag(gainSelectFlag), .fixedCodebookIndex(fixedCodebookIndex), .codebookGain(codebookGain),
		.interopSourceBits(interopSourceBits), .tableWrEn(tableWrEn), .tableWrIndex(tableWrIndex),
		.tableWrValue(tableWrValue), .frameDone(frameDone), .octetData(octetData), .octetLast(octetLast),
		.octetValid(octetValid), .octetReady(octetReady));
	octet_sink_model i_octet_sink_model(.core_clk(core_clk), .arst_n(arst_n), .slow(slow), .octetReady(octetReady));
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	task check(input string nm, input [127:0] seen, input [127:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp)
			begin
				bad_count = bad_count + 1;
				$display("wrong value %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task complete_run;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
			if (bad_count == 0 && cmp_count > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	function [127:0] exp_pkt(input [1:0] t);
		reg     [0:110] d;
		integer         j;
		begin
			for (j = 0; j < 111; j = j + 1)
				d[j] = (tbl[j] < 111) ? interopSourceBits[tbl[j]] : 1'b0;
			case (t)
				2'h0: exp_pkt = {3'h7, spectralParamBits[0:35], pitchLag, pitchFilterBit[0], fixedCodebookIndex[0:11],
					gainSelectFlag[0], codebookGain[0:5], fixedCodebookIndex[13:24], codebookGain[6:11],
					pitchFilterBit[1], fixedCodebookIndex[26:37], gainSelectFlag[1], codebookGain[12:17],
					fixedCodebookIndex[39:50], codebookGain[18:23], 4'h0};
				2'h1: exp_pkt = {2'h2, spectralParamBits, fixedCodebookIndex[0:12], codebookGain[0:5],
					fixedCodebookIndex[13:25], codebookGain[6:11], fixedCodebookIndex[26:38], codebookGain[12:17],
					fixedCodebookIndex[39:51], codebookGain[18:23], 4'h0};
				default: exp_pkt = {8'hDF, 4'h2, 1'h1, d, 4'h0};
			endcase
		end
	endfunction
	function [255:0] rv;
		rv = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
	endfunction
	// Collects octets into packets and compares each whole packet.
	always @(posedge core_clk)
		if (octetValid && octetReady)
		begin
			got = {got[119:0], octetData};
			n = n + 1;
			if (octetLast)
			begin
				check("packet", got, expQ.pop_front());
				check("octets", n, 16);
				n = 0;
				pkts = pkts + 1;
			end
		end
	task send(input [1:0] t, input [255:0] r);
		integer w;
		reg     taken;
		begin
			{interopSourceBits, codebookGain, fixedCodebookIndex, gainSelectFlag, pitchFilterBit} = r[245:55];
			{pitchLag, spectralParamBits} = r[54:0];
			frameType = t;
			frameValid = 1'b1;
			taken = 1'b0;
			// The frame is taken at the first edge that sees frameReady high.
			for (w = 0; w < 100 && !taken; w = w + 1)
			begin
				@(posedge core_clk);
				taken = (frameReady === 1'b1);
				#1;
			end
			frameValid = 1'b0;
			expQ.push_back(exp_pkt(t));
			for (w = 0; w < 400 && frameDone !== 1'b1; w = w + 1)
				@(posedge core_clk) #1;
			check("done", frameDone, 1);
			$display("frame type %0d finished", t);
		end
	endtask
	task wr(input [6:0] idx, input [6:0] val);
		begin
			tableWrIndex = idx;
			tableWrValue = val;
			// Back-to-back writes keep the strobe high; the caller lowers it.
			tableWrEn = 1'b1;
			@(posedge core_clk) #1;
			if (idx < 111)
				tbl[idx] = val;
		end
	endtask
	initial
	begin
		#(8 * 20000);
		bad_count = bad_count + 1;
		complete_run;
	end
	initial
	begin
		{arst_n, frameValid, tableWrEn, slow, frameType, tableWrIndex, tableWrValue} = 0;
		{bad_count, cmp_count, n, pkts, got} = 0;
		{spectralParamBits, pitchLag, pitchFilterBit, gainSelectFlag} = 0;
		{fixedCodebookIndex, codebookGain, interopSourceBits} = 0;
		for (i = 0; i < 111; i = i + 1)
			tbl[i] = i;
		void'($urandom(91506));
		repeat (10) @(posedge core_clk);
		#1 arst_n = 1'b1;
		send(2'h0, {256{1'b1}});
		send(2'h1, 256'h0);
		send(2'h2, rv());
		for (i = 0; i < 50 && pkts != 3; i = i + 1)
			@(posedge core_clk) #1;
		frameType = 2'h3;
		frameValid = 1'b1;
		repeat (4) @(posedge core_clk);
		#1 check("refused", {frameReady, pkts}, {1'b0, 32'd3});
		frameValid = 1'b0;
		$display("refusal test finished");
		wr(7'h00, 7'h6E);
		wr(7'h6E, 7'h00);
		wr(7'h05, 7'h78);
		wr(7'h6F, 7'h03);
		tableWrEn = 1'b0;
		send(2'h2, rv());
		slow = 1'b1;
		for (i = 0; i < 9; i = i + 1)
			send(i % 3, rv());
		slow = 1'b0;
		for (i = 0; i < 200 && expQ.size() > 0; i = i + 1)
			@(posedge core_clk) #1;
		check("packets", pkts, 13);
		complete_run;
	end
endmodule
